// file: rtl/sci_pkg.sv
/*
  constants of the sensor command interface: target address, command codes,
  command field positions, conversion times and their cycle counts.
  assumes a 100 MHz core clock.
*/
package sci_pkg;

  localparam int          CLK_PERIOD_NS   = 10;

  // target address, seven bits
  localparam logic [6:0]  TARGET_ADDR     = 7'h76;

  // command codes
  localparam logic [7:0]  CMD_RESET       = 8'h1E;
  localparam logic [7:0]  CMD_ADC_READ    = 8'h00;
  localparam logic [3:0]  CMD_PROM_HI     = 4'hA;
  localparam logic [2:0]  CMD_CONVERSION_SELECT_BIT_HI     = 3'h2;

  // command field positions
  localparam int          MEASURAND_BIT   = 4;
  localparam int          RATIO_LSB       = 1;
  localparam int          STOP_BIT        = 0;

  // number of oversampling ratios and calibration words
  localparam int          NUM_RATIOS      = 6;
  localparam int          NUM_CAL_WORDS   = 7;
  localparam int          CAL_WORD_W      = 16;
  localparam int          RESULT_W        = 24;

  // byte counts of a read transfer
  localparam logic [1:0]  RESULT_BYTES    = 2'h3;
  localparam logic [1:0]  CAL_BYTES       = 2'h2;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

  // longest conversion time per ratio, in ns (256 .. 8192)
  localparam int          CONVERSION_SELECT_BIT_NS_256     = 560000;
  localparam int          CONVERSION_SELECT_BIT_NS_512     = 1100000;
  localparam int          CONVERSION_SELECT_BIT_NS_1024    = 2170000;
  localparam int          CONVERSION_SELECT_BIT_NS_2048    = 4320000;
  localparam int          CONVERSION_SELECT_BIT_NS_4096    = 8640000;
  localparam int          CONVERSION_SELECT_BIT_NS_8192    = 17280000;

  // cycle counts, rounded up
  localparam int          CONVERSION_SELECT_BIT_CYC_256    = (CONVERSION_SELECT_BIT_NS_256 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CONVERSION_SELECT_BIT_CYC_512    = (CONVERSION_SELECT_BIT_NS_512 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CONVERSION_SELECT_BIT_CYC_1024   = (CONVERSION_SELECT_BIT_NS_1024 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CONVERSION_SELECT_BIT_CYC_2048   = (CONVERSION_SELECT_BIT_NS_2048 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CONVERSION_SELECT_BIT_CYC_4096   = (CONVERSION_SELECT_BIT_NS_4096 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CONVERSION_SELECT_BIT_CYC_8192   = (CONVERSION_SELECT_BIT_NS_8192 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pattern folded into a result whose conversion was disturbed
  localparam logic [23:0] CORRUPT_MASK    = 24'h00_5A5A;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_TX,
    ST_TX_ACK
  } sci_state_type;

endpackage

// file: rtl/sci_top.sv
/*
  sensor command interface: i2c target that decodes one-byte commands,
  runs timed conversions, serves calibration words and conversion results.
  assumes scl and sda inputs synchronous to CORE_CLK, an external open-drain
  wire resolved from SDA_OE, and an adc that presents ADC_SAMPLE at the end
  of the conversion time.
*/
module sci_top #(
  parameter int unsigned CONVERSION_SELECT_BIT_CYC [sci_pkg::NUM_RATIOS] = '{
    sci_pkg::CONVERSION_SELECT_BIT_CYC_256,  sci_pkg::CONVERSION_SELECT_BIT_CYC_512,  sci_pkg::CONVERSION_SELECT_BIT_CYC_1024,
    sci_pkg::CONVERSION_SELECT_BIT_CYC_2048, sci_pkg::CONVERSION_SELECT_BIT_CYC_4096, sci_pkg::CONVERSION_SELECT_BIT_CYC_8192}
) (
  input  wire logic           CORE_CLK,
  input  wire logic           RST,
  input  wire logic           SCL,
  input  wire logic           SDA_IN,
  output logic                SDA_OUT,
  output logic                SDA_OE,
  input  wire logic [111:0]   CAL_WORDS,
  input  wire logic [23:0]    ADC_SAMPLE,
  output logic                ADC_START,
  output logic                ADC_MEASURAND,
  output logic [2:0]          ADC_RATIO,
  output logic                BUSY,
  output logic                RESULT_VALID
);

  sci_pkg::sci_state_type state_ff;
  logic        scl_ff;
  logic        sda_ff;
  logic [3:0]  bit_cnt_ff;
  logic [7:0]  shreg_ff;
  logic [23:0] tx_ff;
  logic [1:0]  tx_bytes_ff;
  logic        oe_ff;
  logic        read_sel_ff;
  logic [2:0]  cal_addr_ff;
  logic [15:0] cal_ff [sci_pkg::NUM_CAL_WORDS];
  logic        load_ff;
  logic        busy_ff;
  logic        valid_ff;
  logic        corrupt_ff;
  logic [31:0] cnt_ff;
  logic [23:0] result_ff;
  logic        start_ff;
  logic        meas_ff;
  logic [2:0]  ratio_ff;

  // bus conditions
  wire         scl_rise   = SCL & ~scl_ff;
  wire         scl_fall   = ~SCL & scl_ff;
  wire         start_cond = SCL & scl_ff & sda_ff & ~SDA_IN;
  wire         stop_cond  = SCL & scl_ff & ~sda_ff & SDA_IN;
  wire         byte_done  = scl_fall & (bit_cnt_ff == sci_pkg::BITS_PER_BYTE);
  wire         addr_match = shreg_ff[7:1] == sci_pkg::TARGET_ADDR;

  // command decode
  wire [2:0]   cmd_field  = shreg_ff[sci_pkg::RATIO_LSB +: 3];
  wire         is_reset   = shreg_ff == sci_pkg::CMD_RESET;
  wire         is_adc_rd  = shreg_ff == sci_pkg::CMD_ADC_READ;
  wire         is_prom    = (shreg_ff[7:4] == sci_pkg::CMD_PROM_HI)
                            & ~shreg_ff[sci_pkg::STOP_BIT];
  wire         is_conversion_select_bit    = (shreg_ff[7:5] == sci_pkg::CMD_CONVERSION_SELECT_BIT_HI)
                            & ~shreg_ff[sci_pkg::STOP_BIT]
                            & (cmd_field < 3'(sci_pkg::NUM_RATIOS));
  wire         cmd_known  = is_reset | is_adc_rd | is_prom | is_conversion_select_bit;
  wire         cmd_done   = (state_ff == sci_pkg::ST_CMD) & byte_done & cmd_known;
  wire         do_reset   = cmd_done & is_reset;
  wire         do_conversion_select_bit    = cmd_done & is_conversion_select_bit;
  wire         read_start = (state_ff == sci_pkg::ST_ADDR_ACK) & scl_fall & shreg_ff[0];
  wire         adc_read   = read_start & ~read_sel_ff;
  wire         conversion_select_bit_end   = busy_ff & (cnt_ff == 32'h0000_0000);

  // answer data of a read transfer
  wire [15:0]  cal_word   = (cal_addr_ff < 3'(sci_pkg::NUM_CAL_WORDS))
                            ? cal_ff[cal_addr_ff] : 16'h0000;
  wire [23:0]  adc_word   = (valid_ff & ~busy_ff) ? result_ff : 24'h00_0000;
  wire [23:0]  tx_load    = read_sel_ff ? {cal_word, 8'h00} : adc_word;
  wire [31:0]  conversion_select_bit_cyc   = 32'(CONVERSION_SELECT_BIT_CYC[cmd_field]);
  wire [23:0]  final_res  = (corrupt_ff | adc_read) ? (ADC_SAMPLE ^ sci_pkg::CORRUPT_MASK)
                                                    : ADC_SAMPLE;

  assign SDA_OUT       = 1'b0;
  assign SDA_OE        = oe_ff;
  assign ADC_START     = start_ff;
  assign ADC_MEASURAND = meas_ff;
  assign ADC_RATIO     = ratio_ff;
  assign BUSY          = busy_ff;
  assign RESULT_VALID  = valid_ff;

  always_ff @(posedge CORE_CLK) begin
    scl_ff <= RST ? 1'b1 : SCL;
    sda_ff <= RST ? 1'b1 : SDA_IN;
  end

  // i2c target sequencer
  always_ff @(posedge CORE_CLK) begin
    if (RST | stop_cond) begin
      state_ff    <= sci_pkg::ST_IDLE;
      oe_ff       <= 1'b0;
      bit_cnt_ff  <= 4'h0;
      shreg_ff    <= 8'h00;
      tx_ff       <= 24'h00_0000;
      tx_bytes_ff <= 2'h0;
    end else if (start_cond) begin
      state_ff   <= sci_pkg::ST_ADDR;
      oe_ff      <= 1'b0;
      bit_cnt_ff <= 4'h0;
    end else begin
      case (state_ff)
        sci_pkg::ST_ADDR, sci_pkg::ST_CMD: begin
          if (scl_rise) begin
            shreg_ff   <= {shreg_ff[6:0], SDA_IN};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          if (byte_done) begin
            bit_cnt_ff <= 4'h0;
            if (state_ff == sci_pkg::ST_ADDR) begin
              state_ff <= addr_match ? sci_pkg::ST_ADDR_ACK : sci_pkg::ST_IDLE;
              oe_ff    <= addr_match;
            end else begin
              state_ff <= sci_pkg::ST_CMD_ACK;
              oe_ff    <= cmd_known;
            end
          end
        end
        sci_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (shreg_ff[0]) begin
              state_ff    <= sci_pkg::ST_TX;
              tx_ff       <= tx_load;
              oe_ff       <= ~tx_load[23];
              bit_cnt_ff  <= 4'h1;
              tx_bytes_ff <= read_sel_ff ? sci_pkg::CAL_BYTES : sci_pkg::RESULT_BYTES;
            end else begin
              state_ff <= sci_pkg::ST_CMD;
              oe_ff    <= 1'b0;
            end
          end
        end
        sci_pkg::ST_CMD_ACK: begin
          if (scl_fall) begin
            state_ff <= sci_pkg::ST_CMD;
            oe_ff    <= 1'b0;
          end
        end
        sci_pkg::ST_TX: begin
          if (byte_done) begin
            state_ff    <= sci_pkg::ST_TX_ACK;
            oe_ff       <= 1'b0;
            tx_bytes_ff <= tx_bytes_ff - 2'h1;
          end else if (scl_fall) begin
            tx_ff      <= {tx_ff[22:0], 1'b0};
            oe_ff      <= ~tx_ff[22];
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        sci_pkg::ST_TX_ACK: begin
          if (scl_rise & SDA_IN) begin
            state_ff <= sci_pkg::ST_IDLE;
          end else if (scl_fall) begin
            if (tx_bytes_ff == 2'h0) begin
              state_ff <= sci_pkg::ST_IDLE;
            end else begin
              state_ff   <= sci_pkg::ST_TX;
              tx_ff      <= {tx_ff[22:0], 1'b0};
              oe_ff      <= ~tx_ff[22];
              bit_cnt_ff <= 4'h1;
            end
          end
        end
        default: begin
          state_ff <= sci_pkg::ST_IDLE;
          oe_ff    <= 1'b0;
        end
      endcase
    end
  end

  // read selection and calibration store
  always_ff @(posedge CORE_CLK) begin
    if (RST | do_reset) begin
      read_sel_ff <= 1'b0;
      cal_addr_ff <= 3'h0;
      load_ff     <= 1'b1;
    end else begin
      load_ff <= 1'b0;
      if (cmd_done & is_adc_rd) begin
        read_sel_ff <= 1'b0;
      end else if (cmd_done & is_prom) begin
        read_sel_ff <= 1'b1;
        cal_addr_ff <= cmd_field;
      end
    end
  end

  for (genvar w = 0; w < sci_pkg::NUM_CAL_WORDS; w++) begin : g_cal
    always_ff @(posedge CORE_CLK) begin
      if (load_ff) begin
        cal_ff[w] <= CAL_WORDS[w*sci_pkg::CAL_WORD_W +: sci_pkg::CAL_WORD_W];
      end
    end
  end

  // conversion timing and result
  always_ff @(posedge CORE_CLK) begin
    if (RST | do_reset) begin
      busy_ff    <= 1'b0;
      valid_ff   <= 1'b0;
      corrupt_ff <= 1'b0;
      cnt_ff     <= 32'h0000_0000;
      result_ff  <= 24'h00_0000;
      start_ff   <= 1'b0;
      meas_ff    <= 1'b0;
      ratio_ff   <= 3'h0;
    end else begin
      start_ff <= do_conversion_select_bit;
      if (do_conversion_select_bit) begin
        busy_ff    <= 1'b1;
        cnt_ff     <= conversion_select_bit_cyc - 32'h0000_0001;
        corrupt_ff <= busy_ff;
        valid_ff   <= 1'b0;
        meas_ff    <= shreg_ff[sci_pkg::MEASURAND_BIT];
        ratio_ff   <= cmd_field;
      end else if (conversion_select_bit_end) begin
        busy_ff    <= 1'b0;
        valid_ff   <= 1'b1;
        corrupt_ff <= 1'b0;
        result_ff  <= final_res;
      end else begin
        if (busy_ff) begin
          cnt_ff <= cnt_ff - 32'h0000_0001;
        end
        if (adc_read & busy_ff) begin
          corrupt_ff <= 1'b1;
        end else if (adc_read) begin
          valid_ff <= 1'b0;
        end
      end
    end
  end

  property p_addr_ack;
    @(posedge CORE_CLK) disable iff (RST)
    (state_ff == sci_pkg::ST_ADDR) && byte_done && addr_match && !start_cond && !stop_cond
      |=> SDA_OE && (state_ff == sci_pkg::ST_ADDR_ACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

  property p_foreign_addr;
    @(posedge CORE_CLK) disable iff (RST)
    (state_ff == sci_pkg::ST_ADDR) && byte_done && !addr_match && !start_cond && !stop_cond
      |=> !SDA_OE && (state_ff == sci_pkg::ST_IDLE);
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address answered");

  property p_reset_cmd;
    @(posedge CORE_CLK) disable iff (RST)
    do_reset && !stop_cond |=> !BUSY && !RESULT_VALID && load_ff ##1 !load_ff;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command did not reinit");

  property p_cal_load;
    @(posedge CORE_CLK) disable iff (RST)
    load_ff |=> cal_ff[0] == $past(CAL_WORDS[15:0]) && cal_ff[6] == $past(CAL_WORDS[111:96]);
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("calibration words not loaded");

  property p_conversion_select_bit_busy;
    @(posedge CORE_CLK) disable iff (RST)
    do_conversion_select_bit && !stop_cond |=> BUSY && ADC_START && ADC_RATIO == $past(cmd_field)
      ##1 !ADC_START;
  endproperty
  a_conversion_select_bit_busy: assert property (p_conversion_select_bit_busy) else $error("conversion did not start");

  property p_busy_until_end;
    @(posedge CORE_CLK) disable iff (RST)
    BUSY && !conversion_select_bit_end && !do_reset |=> BUSY;
  endproperty
  a_busy_until_end: assert property (p_busy_until_end) else $error("busy dropped early");

  property p_read_zero;
    @(posedge CORE_CLK) disable iff (RST)
    adc_read && (busy_ff || !valid_ff) && !stop_cond |=> tx_ff == 24'h00_0000
      && tx_bytes_ff == sci_pkg::RESULT_BYTES;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("result read not zero");

  property p_read_spoils;
    @(posedge CORE_CLK) disable iff (RST)
    adc_read && busy_ff && !conversion_select_bit_end && !stop_cond |=> corrupt_ff && BUSY;
  endproperty
  a_read_spoils: assert property (p_read_spoils) else $error("read did not spoil result");

  property p_overlap;
    @(posedge CORE_CLK) disable iff (RST)
    do_conversion_select_bit && busy_ff && !stop_cond |=> corrupt_ff;
  endproperty
  a_overlap: assert property (p_overlap) else $error("overlap not marked");

  property p_cal_msb;
    @(posedge CORE_CLK) disable iff (RST)
    read_start && read_sel_ff && !stop_cond |=> tx_ff[23:8] == $past(cal_word)
      && SDA_OE == !$past(cal_word[15]) && tx_bytes_ff == sci_pkg::CAL_BYTES;
  endproperty
  a_cal_msb: assert property (p_cal_msb) else $error("calibration word not msb first");

  property p_cmd_ack;
    @(posedge CORE_CLK) disable iff (RST)
    (state_ff == sci_pkg::ST_CMD) && byte_done && !start_cond && !stop_cond
      |=> SDA_OE == $past(cmd_known);
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("command acknowledge wrong");

endmodule

// file: bench/sci_host_model.sv
/*
  i2c host controller model driving scl and its share of the data wire.
  assumes the bench resolves sda from host_oe and the target's enable,
  with a pull-up, and calls the tasks from one process only.
*/
module sci_host_model (
  input  wire logic        clk,
  output logic             scl,
  input  wire logic        sda,
  output logic             host_oe,
  output logic [23:0]      rd_data,
  output logic             rd_done
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl = 1'h1;
    host_oe = 1'h0;
    rd_data = 24'h00_0000;
    rd_done = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one bit: o=1 releases the wire, i is the wire at scl high
  task automatic bit_io(input logic o, output logic i);
    host_oe = ~o;
    tick(4);
    scl = 1'h1;
    tick(2);
    i = sda;
    tick(2);
    scl = 1'h0;
    tick(3);
  endtask

  task automatic start_c();
    host_oe = 1'h0;
    scl = 1'h1;
    tick(4);
    host_oe = 1'h1;
    tick(4);
    scl = 1'h0;
    tick(3);
  endtask

  task automatic stop_c();
    host_oe = 1'h1;
    tick(4);
    scl = 1'h1;
    tick(4);
    host_oe = 1'h0;
    tick(4);
  endtask

  // frees a data wire held low: scl pulses with the wire released
  task automatic unstick(input int n);
    host_oe = 1'h0;
    for (int k = 0; k < n; k++) begin
      scl = 1'h0;
      tick(4);
      scl = 1'h1;
      tick(4);
    end
  endtask

  task automatic xfer(input logic [7:0] b, output logic ack);
    logic i;
    for (int k = 7; k >= 0; k--) bit_io(b[k], i);
    bit_io(1'h1, i);
    ack = (i === 1'h0);
  endtask

  task automatic cmd(input logic [6:0] adr, input logic [7:0] c,
                     output logic a0, output logic a1);
    start_c();
    xfer({adr, 1'h0}, a0);
    a1 = 1'h0;
    if (a0) xfer(c, a1);
    stop_c();
  endtask

  // separate read transaction after the command
  task automatic fetch(input int n);
    logic        a;
    logic        i;
    logic [23:0] d;
    d = 24'h00_0000;
    start_c();
    xfer({sci_pkg::TARGET_ADDR, 1'h1}, a);
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 8; j++) begin
        bit_io(1'h1, i);
        d = {d[22:0], i};
      end
      bit_io(k == n - 1, i);
    end
    stop_c();
    rd_data = d;
    rd_done = 1'h1;
    tick(1);
    rd_done = 1'h0;
  endtask
endmodule

// file: bench/tb_sensor_i2c_command_interface.sv
/*
  self-checking bench of the sensor command interface.
  assumes a pull-up on sda and short conversion counts set here.
*/
module tb_sensor_i2c_command_interface;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned CYC [sci_pkg::NUM_RATIOS] = '{600, 700, 800, 900, 1000, 1100};

  logic           core_clk = 1'h0;
  logic           rst = 1'h1;
  logic           scl;
  logic           host_oe;
  logic           sda_out;
  logic           sda_oe;
  logic [111:0]   cal = 112'h0;
  logic [23:0]    sample = 24'h00_0000;
  logic           busy;
  logic           valid;
  logic           meas;
  logic [2:0]     ratio;
  logic [23:0]    rd_data;
  logic           rd_done;
  wire  logic     sda = (sda_oe ? sda_out : 1'h1) & ~host_oe;
  logic [23:0]    exp_q[$];
  int             n_errors = 0;
  int             checks_done = 0;
  int             bcnt = 0;
  int             blen = 0;
  logic           a0;
  logic           a1;
  logic           adc_start;
  int             n_start = 0;

  always #5 core_clk = ~core_clk;

  sci_top #(.CONVERSION_SELECT_BIT_CYC(CYC)) i_sci_top (
    .CORE_CLK(core_clk), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .CAL_WORDS(cal), .ADC_SAMPLE(sample), .ADC_START(adc_start),
    .ADC_MEASURAND(meas), .ADC_RATIO(ratio), .BUSY(busy), .RESULT_VALID(valid));

  sci_host_model i_sci_host_model (
    .clk(core_clk), .scl(scl), .sda(sda), .host_oe(host_oe),
    .rd_data(rd_data), .rd_done(rd_done));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // read results are compared in arrival order
  always @(posedge core_clk) begin
    if (rd_done === 1'h1) begin
      check(rd_data, exp_q.size() ? exp_q.pop_front() : 24'hxx_xxxx);
    end
  end

  // conversion starts seen on the adc side
  always @(posedge core_clk) begin
    if (adc_start === 1'h1) n_start++;
  end

  // length of the last busy period
  always @(posedge core_clk) begin
    if (busy === 1'h1) bcnt++;
    else begin
      if (bcnt != 0) blen = bcnt;
      bcnt = 0;
    end
  end

  task automatic send(input logic [7:0] c, input logic ok);
    logic x0, x1;
    i_sci_host_model.cmd(sci_pkg::TARGET_ADDR, c, x0, x1);
    check(24'({x0, x1}), ok ? 24'h00_0003 : 24'h00_0002);
  endtask

  task automatic result(input logic [23:0] e);
    send(sci_pkg::CMD_ADC_READ, 1'h1);
    exp_q.push_back(e);
    i_sci_host_model.fetch(3);
  endtask

  task automatic cal_read(input int w);
    send({sci_pkg::CMD_PROM_HI, 3'(w), 1'h0}, 1'h1);
    exp_q.push_back(w < 7 ? 24'(cal[16*w +: 16]) : 24'h00_0000);
    i_sci_host_model.fetch(2);
  endtask

  // host waits until the conversion is over
  task automatic wait_idle();
    for (int k = 0; k < 3000 && busy !== 1'h0; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (busy !== 1'h0) begin
      check(24'(busy), 24'h00_0000);
      tally_and_finish();
    end else begin
      i_sci_host_model.tick(2);
    end
  endtask

  initial begin
    void'($urandom(31));
    cal = {$urandom(), $urandom(), $urandom(), 16'($urandom())};
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'h0;
    i_sci_host_model.cmd(7'h37, sci_pkg::CMD_RESET, a0, a1);
    check(24'(a0), 24'h00_0000);
    // address only, clock stopped in the acknowledge slot
    i_sci_host_model.start_c();
    for (int k = 6; k >= 0; k--) i_sci_host_model.bit_io(sci_pkg::TARGET_ADDR[k], a1);
    i_sci_host_model.bit_io(1'h0, a1);
    check(24'(sda_oe), 24'h00_0001);
    i_sci_host_model.unstick(9);
    check(24'({sda_oe, sda}), 24'h00_0001);
    send(sci_pkg::CMD_RESET, 1'h1);
    send(8'h41, 1'h0);
    $display("test address and reset done");
    for (int w = 0; w < 8; w++) cal_read(w);
    $display("test calibration done");
    result(24'h00_0000);
    for (int m = 0; m < 2; m++) begin
      for (int r = 0; r < sci_pkg::NUM_RATIOS; r++) begin
        sample = 24'($urandom());
        n_start = 0;
        send({sci_pkg::CMD_CONVERSION_SELECT_BIT_HI, 1'(m), 3'(r), 1'h0}, 1'h1);
        check(24'({busy, meas, ratio}), 24'({1'h1, 1'(m), 3'(r)}));
        check(24'(n_start), 24'h00_0001);
        wait_idle();
        check(24'(blen), 24'(CYC[r]));
        check(24'(valid), 24'h00_0001);
        result(sample);
        result(24'h00_0000);
      end
    end
    $display("test conversions done");
    sample = 24'($urandom());
    send(8'h4A, 1'h1);
    result(24'h00_0000);
    check(24'(busy), 24'h00_0001);
    wait_idle();
    result(sample ^ sci_pkg::CORRUPT_MASK);
    send(8'h40, 1'h1);
    send(8'h52, 1'h1);
    wait_idle();
    result(sample ^ sci_pkg::CORRUPT_MASK);
    $display("test misuse done");
    send(8'h48, 1'h1);
    cal = {$urandom(), $urandom(), $urandom(), 16'($urandom())};
    send(sci_pkg::CMD_RESET, 1'h1);
    i_sci_host_model.tick(2);
    check(24'({busy, valid}), 24'h00_0000);
    cal_read(0);
    cal_read(6);
    result(24'h00_0000);
    $display("test reset during conversion done");
    tally_and_finish();
  end
endmodule
